/* File: design/wdt_consts.svh */
// Purpose: Named constants for the watchdog block: register map, fields, counts.
// Assumes: Word-aligned AHB-Lite access, byte address is four times the index.
// Notes: Definitions only.
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH
// ----------------------------------------
// Register indices and decode
// ----------------------------------------
`define WDT_IDX_SERVICE 16'hFFFF
`define WDT_IDX_CFG1 16'h001E
`define WDT_IDX_CFG2 16'h001F
`define WDT_IDX_STATUS 16'h0020
`define WDT_ADDR_HI_ZERO 14'h0000
`define WDT_HRESP_OKAY 1'b0
// ----------------------------------------
// Field positions
// ----------------------------------------
`define WDT_B_DISABLE 0
`define WDT_B_STOP_EN 1
`define WDT_B_SHORT_STOP_RECOVERY 2
`define WDT_B_RANGE 3
`define WDT_B_PWR_DIS 4
`define WDT_B_RST_DIS 5
`define WDT_B_LV_STOP 6
`define WDT_B_LONG_SEL 7
`define WDT_B_OSC_KEEP 0
`define WDT_B_FLAG 0
`define WDT_B_STOPPED 1
`define WDT_B_OFF 2
// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define WDT_CFG_RST 8'h00
`define WDT_TO_LONG 18'h3FFF0
`define WDT_TO_SHORT 18'h01FF0
`define WDT_SVC_KEEP 12'h00F
`define WDT_PULSE_LEN 6'h20
`define WDT_POR_DLY 13'h1000
`define WDT_REC_SHORT 13'h0020
`define WDT_REC_LONG 13'h1000
`endif

/* File: design/wdt_pkg.sv */
// Purpose: Shared types of the watchdog block.
// Assumes: Nothing beyond the constants header.
// Notes: One-hot power state.
package wdt_pkg;
   // ----------------------------------------
   // Power state
   // ----------------------------------------
   typedef enum logic [2:0] {
      WDT_RUN = 3'h1,
      WDT_STOP = 3'h2,
      WDT_RECOV = 3'h4
   } wdt_pwr_t;
endpackage

/* File: design/wdt_cnt_if.sv */
// Purpose: Carrier between the watchdog control and its counter chain.
// Assumes: Single clock domain.
// Notes: Clears are levels sampled every cycle.
`timescale 1ns/1ps
interface wdt_cnt_if;
   logic tick;
   logic clr_all;
   logic clr_presc;
   logic clr_service;
   logic long_sel;
   logic overflow;
   modport core (input tick, input clr_all, input clr_presc, input clr_service,
      input long_sel, output overflow);
   modport ctrl (output tick, output clr_all, output clr_presc, output clr_service,
      output long_sel, input overflow);
endinterface

/* File: design/wdt_core.sv */
// Purpose: Prescaler and counter chain of the watchdog, with overflow pulse.
// Assumes: tick is a one-cycle enable per watchdog clock period.
// Notes: Counter and prescaler are treated as one 18-bit value.
`timescale 1ns/1ps
`include "wdt_consts.svh"
module wdt_core import wdt_pkg::*; #(
   parameter logic [17:0] TO_LONG = `WDT_TO_LONG,
   parameter logic [17:0] TO_SHORT = `WDT_TO_SHORT
) (
   input wire logic hclk,
   input wire logic hresetn,
   wdt_cnt_if.core cif
);
   logic [11:0] presc_r;
   logic [5:0] cnt_r;
   logic ovf_r;
   logic [17:0] value;
   logic [17:0] target;
   logic [17:0] value_inc;
   logic hit;
   // ----------------------------------------
   // Chain value and terminal compare
   // ----------------------------------------
   assign value = {cnt_r, presc_r};
   assign value_inc = value + 18'h00001;
   assign target = cif.long_sel ? (TO_LONG - 18'h00001) : (TO_SHORT - 18'h00001);
   assign hit = cif.tick && (value == target);
   assign cif.overflow = ovf_r;
   // Clears take priority over counting so a service never races a tick
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         presc_r <= 12'h000;
         cnt_r <= 6'h00;
         ovf_r <= 1'b0;
      end else if (cif.clr_all) begin
         presc_r <= 12'h000;
         cnt_r <= 6'h00;
         ovf_r <= 1'b0;
      end else begin
         ovf_r <= hit && !cif.clr_presc && !cif.clr_service;
         if (cif.clr_presc) begin
            presc_r <= 12'h000;
         end else if (cif.clr_service) begin
            presc_r <= presc_r & `WDT_SVC_KEEP;
            cnt_r <= 6'h00;
         end else if (cif.tick) begin
            {cnt_r, presc_r} <= value_inc;
         end
         if (cif.clr_presc && cif.clr_service) begin
            cnt_r <= 6'h00;
         end
      end
   end
endmodule

/* File: design/wdt_delay.sv */
// Purpose: Tick-driven delay of programmable length with a done pulse.
// Assumes: start and tick are one-cycle pulses.
// Notes: A new start restarts the count.
`timescale 1ns/1ps
module wdt_delay (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic start,
   input wire logic tick,
   input wire logic [12:0] len,
   output logic done
);
   logic [12:0] cnt_r;
   logic done_r;
   assign done = done_r;
   // Count down on ticks; done pulses in the cycle after the tick that ends the wait
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_r <= 13'h0000;
         done_r <= 1'b0;
      end else if (start) begin
         cnt_r <= len;
         done_r <= 1'b0;
      end else begin
         done_r <= tick && (cnt_r == 13'h0001);
         if (tick && (cnt_r != 13'h0000)) begin
            cnt_r <= cnt_r - 13'h0001;
         end
      end
   end
endmodule

/* File: design/wdt_top.sv */
// Purpose: Watchdog with write-once configuration and stop-mode control, AHB-Lite slave.
// Assumes: wdog_tick and osc_tick are one-cycle enables in the hclk domain.
// Notes: Reads take one wait state; writes take none.
//
// How it works
// - Six-bit counter behind twelve-bit prescaler, both stepped by watchdog clock ticks.
// - Overflow at 262,128 ticks with long select, else 8176; reset clears select.
// - Overflow holds reset pin low 32 ticks and sets the watchdog cause flag.
// - Reading the service location returns the reset vector low byte.
// - Executing stop clears the prescaler.
// - Prescaler is cleared 4096 oscillator ticks after power-up.
// - Any internal reset clears prescaler and counter.
// - A reset vector fetch clears the prescaler.
// - Disable bit set stops the watchdog; clear lets it run.
// - Monitor mode holds watchdog off by test voltage, or until power-on if blank.
// - Break with test voltage on reset pin disables the watchdog.
// - No processor interrupt is ever raised; only a reset.
// - Counting continues in wait mode.
// - Stop mode gates off the watchdog clock.
// - Stop with stop disabled gives an illegal-opcode reset instead.
// - Stop exits after 32 oscillator ticks with short recovery, else 4096.
// - Exit caused by low-voltage reset always uses the long recovery.
// - Generator clocks run in stop only with oscillator-in-stop set, else low.
// - Low-voltage detector runs in stop when asked and its power is enabled.
// - Voltage range bit is cleared only by power-on reset.
// - Configuration takes one write per reset, always readable, cleared by reset.
//
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "wdt_consts.svh"
module wdt_top import wdt_pkg::*; #(
   parameter logic [17:0] TO_LONG = `WDT_TO_LONG,
   parameter logic [17:0] TO_SHORT = `WDT_TO_SHORT
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic wdog_tick,
   input wire logic osc_tick,
   input wire logic sys_reset_in,
   input wire logic [7:0] reset_vector_lo,
   input wire logic vector_fetch,
   input wire logic stop_exec,
   input wire logic stop_wake,
   input wire logic stop_wake_lvi,
   input wire logic monitor_entry,
   input wire logic irq_at_test_high_voltage,
   input wire logic rst_at_test_high_voltage,
   input wire logic blank_vectors,
   input wire logic break_active,
   input wire logic internal_gen_clock,
   input wire logic external_gen_clock,
   output logic reset_pin_n,
   output logic wdt_cause_set,
   output logic illegal_op_reset,
   output logic stop_mode,
   output logic stop_exit,
   output logic internal_gen_clock_out,
   output logic external_gen_clock_out,
   output logic lvd_enable,
   output logic lvd_reset_enable,
   output logic lvd_range_5v
);
   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   wdt_cnt_if cif ();
   wdt_pwr_t state_r, state_nxt;
   logic [7:0] cfg1_r, cfg1_nxt;
   logic cfg2_r;
   logic cfg1_lock_r, cfg2_lock_r, range_lock_r;
   logic flag_r, flag_nxt;
   logic mon_test_high_voltage_r, mon_blank_r;
   logic [5:0] pulse_cnt_r, pulse_cnt_nxt;
   logic rst_pin_n_r;
   logic illegal_r, stop_exit_r;
   logic por_armed_r;
   logic int_clk_r, ext_clk_r;
   logic lvd_en_r, lvd_rst_en_r, lvd_5v_r;
   logic wr_ph_r, rd_ph_r, rd_ph2_r;
   logic [15:0] wr_idx_r, rd_idx_r;
   logic [31:0] hrdata_r;
   logic accept, addr_ok;
   logic [15:0] addr_idx;
   logic wr_svc, wr_cfg1, wr_cfg2, wr_status;
   logic int_rst, wd_off;
   logic stop_ok, stop_bad, wake_go, por_done, rec_done;
   logic [12:0] rec_len;
   logic clk_gate;
   logic [7:0] status_val;
   logic [7:0] rd_val;
   // ----------------------------------------
   // AHB-Lite address decode
   // ----------------------------------------
   assign accept = hsel && htrans[1] && hready;
   assign addr_ok = (haddr[31:18] == `WDT_ADDR_HI_ZERO);
   assign addr_idx = haddr[17:2];
   assign wr_svc = wr_ph_r && (wr_idx_r == `WDT_IDX_SERVICE);
   assign wr_cfg1 = wr_ph_r && (wr_idx_r == `WDT_IDX_CFG1);
   assign wr_cfg2 = wr_ph_r && (wr_idx_r == `WDT_IDX_CFG2);
   assign wr_status = wr_ph_r && (wr_idx_r == `WDT_IDX_STATUS);
   // Reads stall one cycle so data always reflects a write just before
   assign hreadyout = !rd_ph_r;
   assign hresp = `WDT_HRESP_OKAY;
   assign hrdata = hrdata_r;
   // Bus phase tracking; unmapped addresses fall through to a zero read
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_ph_r <= 1'b0;
         rd_ph_r <= 1'b0;
         rd_ph2_r <= 1'b0;
         wr_idx_r <= 16'h0000;
         rd_idx_r <= 16'h0000;
      end else begin
         wr_ph_r <= accept && hwrite && addr_ok;
         rd_ph_r <= accept && !hwrite;
         rd_ph2_r <= rd_ph_r;
         if (accept) begin
            wr_idx_r <= addr_idx;
            rd_idx_r <= addr_ok ? addr_idx : 16'h0001;
         end
      end
   end
   // ----------------------------------------
   // Read mux
   // ----------------------------------------
   assign status_val = {5'h00, wd_off, (state_r != WDT_RUN), flag_r};
   assign rd_val = (rd_idx_r == `WDT_IDX_SERVICE) ? reset_vector_lo :
      (rd_idx_r == `WDT_IDX_CFG1) ? cfg1_r :
      (rd_idx_r == `WDT_IDX_CFG2) ? {7'h00, cfg2_r} :
      (rd_idx_r == `WDT_IDX_STATUS) ? status_val : 8'h00;
   // Read data is loaded in the stalled cycle and held afterwards
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_r <= 32'h00000000;
      end else if (rd_ph_r) begin
         hrdata_r <= {24'h000000, rd_val};
      end
   end
   // ----------------------------------------
   // Configuration latches
   // ----------------------------------------
   assign int_rst = sys_reset_in || !rst_pin_n_r;
   // Range bit follows its own lock so an internal reset leaves it alone
   always_comb begin
      cfg1_nxt = cfg1_r;
      if (wr_cfg1 && !cfg1_lock_r) begin
         cfg1_nxt = hwdata[7:0];
         cfg1_nxt[`WDT_B_RANGE] = cfg1_r[`WDT_B_RANGE];
      end
      if (wr_cfg1 && !range_lock_r) begin
         cfg1_nxt[`WDT_B_RANGE] = hwdata[`WDT_B_RANGE];
      end
      if (int_rst) begin
         cfg1_nxt = `WDT_CFG_RST;
         cfg1_nxt[`WDT_B_RANGE] = cfg1_r[`WDT_B_RANGE];
      end
   end
   // One write after each reset; later writes are ignored silently
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg1_r <= `WDT_CFG_RST;
         cfg2_r <= 1'b0;
         cfg1_lock_r <= 1'b0;
         cfg2_lock_r <= 1'b0;
         range_lock_r <= 1'b0;
      end else begin
         cfg1_r <= cfg1_nxt;
         range_lock_r <= range_lock_r || wr_cfg1;
         if (int_rst) begin
            cfg2_r <= 1'b0;
            cfg1_lock_r <= 1'b0;
            cfg2_lock_r <= 1'b0;
         end else begin
            cfg1_lock_r <= cfg1_lock_r || wr_cfg1;
            cfg2_lock_r <= cfg2_lock_r || wr_cfg2;
            if (wr_cfg2 && !cfg2_lock_r) begin
               cfg2_r <= hwdata[`WDT_B_OSC_KEEP];
            end
         end
      end
   end
   // ----------------------------------------
   // Disable sources
   // ----------------------------------------
   // Test voltage hold ends when the voltage leaves both pins; set wins
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mon_test_high_voltage_r <= 1'b0;
         mon_blank_r <= 1'b0;
      end else begin
         mon_test_high_voltage_r <= (monitor_entry && irq_at_test_high_voltage) ||
            (mon_test_high_voltage_r && (irq_at_test_high_voltage || rst_at_test_high_voltage));
         mon_blank_r <= mon_blank_r ||
            (monitor_entry && blank_vectors && !irq_at_test_high_voltage);
      end
   end
   assign wd_off = cfg1_r[`WDT_B_DISABLE] || mon_test_high_voltage_r || mon_blank_r ||
      (break_active && rst_at_test_high_voltage);
   // ----------------------------------------
   // Counter chain hookup
   // ----------------------------------------
   // Wait mode has no gating term, so the chain keeps counting there
   assign cif.tick = wdog_tick && (state_r == WDT_RUN) && !wd_off;
   assign cif.clr_all = int_rst || wd_off;
   assign cif.clr_presc = stop_ok || por_done || vector_fetch;
   assign cif.clr_service = wr_svc;
   assign cif.long_sel = cfg1_r[`WDT_B_LONG_SEL];
   wdt_core #(
      .TO_LONG(TO_LONG),
      .TO_SHORT(TO_SHORT)
   ) u_core (
      .hclk(hclk),
      .hresetn(hresetn),
      .cif(cif)
   );
   // ----------------------------------------
   // Reset pulse and cause flag
   // ----------------------------------------
   // The pulse counts raw ticks; stop gating must not stretch a reset
   assign pulse_cnt_nxt = cif.overflow ? `WDT_PULSE_LEN :
      (wdog_tick && (pulse_cnt_r != 6'h00)) ? pulse_cnt_r - 6'h01 : pulse_cnt_r;
   // Software clears the flag by writing one; a new overflow wins
   assign flag_nxt = cif.overflow ||
      (flag_r && !(wr_status && hwdata[`WDT_B_FLAG]));
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pulse_cnt_r <= 6'h00;
         rst_pin_n_r <= 1'b1;
         flag_r <= 1'b0;
      end else begin
         pulse_cnt_r <= pulse_cnt_nxt;
         rst_pin_n_r <= (pulse_cnt_nxt == 6'h00);
         flag_r <= flag_nxt;
      end
   end
   assign reset_pin_n = rst_pin_n_r;
   assign wdt_cause_set = cif.overflow;
   // ----------------------------------------
   // Power-up prescaler clear
   // ----------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         por_armed_r <= 1'b0;
      end else begin
         por_armed_r <= 1'b1;
      end
   end
   wdt_delay u_por_dly (
      .hclk(hclk),
      .hresetn(hresetn),
      .start(!por_armed_r),
      .tick(osc_tick),
      .len(`WDT_POR_DLY),
      .done(por_done)
   );
   // ----------------------------------------
   // Stop sequence
   // ----------------------------------------
   assign stop_ok = stop_exec && (state_r == WDT_RUN) && cfg1_r[`WDT_B_STOP_EN];
   assign stop_bad = stop_exec && (state_r == WDT_RUN) && !cfg1_r[`WDT_B_STOP_EN];
   assign wake_go = stop_wake && (state_r == WDT_STOP);
   // Low-voltage wake forces the long wait whatever the short bit says
   assign rec_len = (cfg1_r[`WDT_B_SHORT_STOP_RECOVERY] && !stop_wake_lvi) ?
      `WDT_REC_SHORT : `WDT_REC_LONG;
   wdt_delay u_rec_dly (
      .hclk(hclk),
      .hresetn(hresetn),
      .start(wake_go),
      .tick(osc_tick),
      .len(rec_len),
      .done(rec_done)
   );
   // Recovery is not aborted by internal reset, so a low-voltage exit completes
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         WDT_RUN: begin
            if (stop_ok) begin
               state_nxt = WDT_STOP;
            end
         end
         WDT_STOP: begin
            if (wake_go) begin
               state_nxt = WDT_RECOV;
            end
         end
         WDT_RECOV: begin
            if (rec_done) begin
               state_nxt = WDT_RUN;
            end
         end
         default: begin
            state_nxt = WDT_RUN;
         end
      endcase
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r <= WDT_RUN;
         illegal_r <= 1'b0;
         stop_exit_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         illegal_r <= stop_bad;
         stop_exit_r <= (state_r == WDT_RECOV) && rec_done;
      end
   end
   assign illegal_op_reset = illegal_r;
   assign stop_exit = stop_exit_r;
   assign stop_mode = (state_r != WDT_RUN);
   // ----------------------------------------
   // Clock and low-voltage controls
   // ----------------------------------------
   assign clk_gate = (state_r == WDT_RUN) || cfg2_r;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         int_clk_r <= 1'b0;
         ext_clk_r <= 1'b0;
         lvd_en_r <= 1'b0;
         lvd_rst_en_r <= 1'b0;
         lvd_5v_r <= 1'b0;
      end else begin
         int_clk_r <= internal_gen_clock && clk_gate;
         ext_clk_r <= external_gen_clock && clk_gate;
         lvd_en_r <= !cfg1_r[`WDT_B_PWR_DIS] &&
            ((state_r == WDT_RUN) || cfg1_r[`WDT_B_LV_STOP]);
         lvd_rst_en_r <= !cfg1_r[`WDT_B_RST_DIS];
         lvd_5v_r <= cfg1_r[`WDT_B_RANGE];
      end
   end
   assign internal_gen_clock_out = int_clk_r;
   assign external_gen_clock_out = ext_clk_r;
   assign lvd_enable = lvd_en_r;
   assign lvd_reset_enable = lvd_rst_en_r;
   assign lvd_range_5v = lvd_5v_r;
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   chk_svc_read_vector: assert property (
      rd_ph_r && (rd_idx_r == `WDT_IDX_SERVICE) |=> hrdata == {24'h000000, $past(reset_vector_lo)})
      else $error("service read did not return vector byte");
   chk_ovf_pin_low: assert property (
      cif.overflow |=> !reset_pin_n [*8])
      else $error("overflow did not pull reset pin low");
   chk_ovf_sets_flag: assert property (
      cif.overflow |=> flag_r && wdt_cause_set == 1'b0)
      else $error("overflow did not set cause flag");
   chk_off_no_ovf: assert property (
      wd_off && $past(wd_off) |-> !cif.overflow && u_core.value == 18'h00000)
      else $error("disabled watchdog counted or overflowed");
   chk_cfg_write_once: assert property (
      wr_cfg1 && cfg1_lock_r && !int_rst |=> cfg1_r == $past(cfg1_r))
      else $error("locked configuration changed");
   chk_stop_illegal: assert property (
      stop_bad |=> illegal_op_reset && !stop_mode)
      else $error("disabled stop did not give illegal reset");
   chk_stop_no_tick: assert property (
      stop_mode |-> !cif.tick)
      else $error("watchdog ticked in stop");
   chk_clk_low_stop: assert property (
      stop_mode && !cfg2_r |=> !internal_gen_clock_out && !external_gen_clock_out)
      else $error("generator clocks not held low in stop");
   chk_range_kept: assert property (
      sys_reset_in |=> cfg1_r[`WDT_B_RANGE] == $past(cfg1_r[`WDT_B_RANGE]))
      else $error("range bit changed by internal reset");
   chk_lvi_long_rec: assert property (
      wake_go && stop_wake_lvi |=> u_rec_dly.cnt_r == `WDT_REC_LONG)
      else $error("low-voltage wake used short recovery");
   chk_short_rec: assert property (
      wake_go && !stop_wake_lvi && cfg1_r[`WDT_B_SHORT_STOP_RECOVERY] |=> u_rec_dly.cnt_r == `WDT_REC_SHORT)
      else $error("short recovery not loaded");
   chk_service_clear: assert property (
      wr_svc && !int_rst && !wd_off && !cif.clr_presc |=> u_core.cnt_r == 6'h00)
      else $error("service write did not clear counter");
   cov_overflow: cover property (cif.overflow ##1 !reset_pin_n);
   cov_stop_exit: cover property (rec_done ##1 stop_exit);
   cov_illegal: cover property (stop_bad ##1 illegal_op_reset);
   cov_service: cover property (wr_svc);
endmodule

/* File: sim/wdt_partner.sv */
// Purpose: Far-side model: watchdog and oscillator ticks from the clock logic.
// Assumes: Ticks are one-cycle enables in the hclk domain.
// Notes: slow stretches the watchdog tick to one in four cycles.
`timescale 1ns/1ps
module wdt_partner (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic run,
   input wire logic slow,
   output logic wdog_tick,
   output logic osc_tick
);
   logic [1:0] div_r;
   // Free divider; ticks gated by run so counts start at a known edge
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_r <= 2'h0;
      end else begin
         div_r <= div_r + 2'h1;
      end
   end
   assign wdog_tick = run && (!slow || div_r == 2'h0);
   assign osc_tick = run;
endmodule

/* File: sim/wdt_top_tb.sv */
// Purpose: Self-checking bench of the watchdog block over AHB-Lite.
// Assumes: One slave, so hready is hreadyout.
// Notes: Short timeout parameters keep the run brief.
`timescale 1ns/1ps
module wdt_top_tb;
   localparam logic [17:0] T_LONG = 18'h00100;
   logic hclk, hresetn, hsel, hwrite, run, slow, sys_rst, stop_x, wake, rdy_q, rd_ph;
   logic hreadyout, wtick, otick, pin_n, cause, ill, stop_m, stop_e;
   logic low_voltage_detector, test_high_voltage, vfetch, icko;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata;
   logic [7:0] rv, v;
   int errors, checks_done, n, n_cause, n0, seed;
   logic [31:0] exp_q[$];
   wdt_partner u_far (.hclk(hclk), .hresetn(hresetn), .run(run), .slow(slow),
      .wdog_tick(wtick), .osc_tick(otick));
   wdt_top #(.TO_LONG(T_LONG), .TO_SHORT(18'h00040)) DUT (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(), .wdog_tick(wtick), .osc_tick(otick), .sys_reset_in(sys_rst),
      .reset_vector_lo(rv), .vector_fetch(vfetch), .stop_exec(stop_x), .stop_wake(wake),
      .stop_wake_lvi(low_voltage_detector), .monitor_entry(1'b0), .irq_at_test_high_voltage(1'b0), .rst_at_test_high_voltage(test_high_voltage),
      .blank_vectors(1'b0), .break_active(sys_rst), .internal_gen_clock(run),
      .external_gen_clock(slow), .reset_pin_n(pin_n), .wdt_cause_set(cause),
      .illegal_op_reset(ill), .stop_mode(stop_m), .stop_exit(stop_e),
      .internal_gen_clock_out(icko), .external_gen_clock_out(), .lvd_enable(),
      .lvd_reset_enable(), .lvd_range_5v());
   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end
   // ----------------------------------------
   // Compare, verdict and bus master
   // ----------------------------------------
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic results();
      if (errors == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Ready sampled mid-cycle, so the rising edge never races it
   always @(negedge hclk) rdy_q <= hreadyout;
   task automatic wait_rdy();
      for (int i = 0; i < 64; i++) begin
         @(posedge hclk);
         if (rdy_q) return;
      end
      errors++;
      results();
   endtask
   task automatic bus(input logic w, input logic [15:0] idx, input logic [7:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {14'h0000, idx, 2'h0};
      htrans <= 2'h2;
      hwrite <= w;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= {24'h000000, d};
      wait_rdy();
   endtask
   task automatic rd(input logic [15:0] idx, input logic [7:0] e);
      exp_q.push_back({24'h000000, e});
      bus(1'b0, idx, 8'h00);
   endtask
   // Watcher: takes the oldest note when read data stands
   always @(negedge hclk) begin
      if (cause === 1'b1) n_cause++;
      if (rd_ph && hreadyout) begin
         rd_ph = 1'b0;
         cmp(hrdata, exp_q.pop_front());
      end
      if (hsel && htrans[1] && !hwrite && hreadyout) rd_ph = 1'b1;
   end
   // Counts ticks until the chosen output shows its event; bounded
   task automatic count_to(input int sel, output int cnt);
      int t;
      cnt = 0;
      t = 0;
      for (int i = 0; i < 20000; i++) begin
         @(negedge hclk);
         if ((sel == 0 && cause === 1'b1) || (sel == 1 && pin_n === 1'b1)) return;
         // Exit is registered two edges after the last recovery tick, one edge after rec_done
         if (sel == 2 && stop_e === 1'b1) begin
            cnt -= t;
            return;
         end
         t = (sel == 2) ? int'(otick) : int'(wtick);
         cnt += t;
      end
      errors++;
      results();
   endtask
   task automatic pulse_stop();
      @(posedge hclk);
      stop_x <= 1'b1;
      @(posedge hclk);
      stop_x <= 1'b0;
      @(negedge hclk);
   endtask
   initial begin
      {hsel, hwrite, run, slow, sys_rst, stop_x, wake, rd_ph, hresetn} = 9'h000;
      {low_voltage_detector, test_high_voltage, vfetch} = 3'h0;
      {htrans, haddr, hwdata, errors, checks_done, n_cause, rdy_q} = '0;
      seed = 32'h32FA;
      rv = 8'($random(seed));
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      rd(16'h001E, 8'h00);
      rd(16'hFFFF, rv);
      rd(16'h0040, 8'h00);
      v = 8'($random(seed));
      v = {1'b1, v[6:3], 3'h2};
      bus(1'b1, 16'h001E, v);
      bus(1'b1, 16'h001E, ~v);
      rd(16'h001E, v);
      @(posedge hclk);
      run <= 1'b1;
      slow <= 1'b1;
      count_to(0, n);
      cmp(n, 32'(T_LONG));
      count_to(1, n);
      cmp(n, 32'h20);
      rd(16'h0020, 8'h01);
      rd(16'h001E, {4'h0, v[3], 3'h0});
      bus(1'b1, 16'h001F, 8'h01);
      bus(1'b1, 16'h001E, 8'h06);
      pulse_stop();
      cmp(32'(stop_m), 32'h1);
      cmp(32'(icko), 32'h1);
      n0 = n_cause;
      repeat (600) @(posedge hclk);
      cmp(n_cause, n0);
      {wake, low_voltage_detector} <= 2'h3;
      @(posedge hclk);
      {wake, low_voltage_detector} <= 2'h0;
      count_to(2, n);
      cmp(n, 32'h1000);
      @(posedge hclk);
      {sys_rst, test_high_voltage, vfetch} <= 3'h7;
      rd(16'h0020, 8'h05);
      {sys_rst, test_high_voltage, vfetch} <= 3'h0;
      rd(16'h001E, {4'h0, v[3], 3'h0});
      bus(1'b1, 16'h001E, 8'h01);
      repeat (600) @(posedge hclk);
      cmp(n_cause, n0);
      rd(16'h0020, 8'h05);
      pulse_stop();
      cmp(32'(ill), 32'h1);
      cmp(32'(stop_m), 32'h0);
      results();
   end
endmodule
